//--- shared/bswc_defs.vh
`ifndef BSWC_DEFS_VH
`define BSWC_DEFS_VH

// register byte offsets
`define BSWC_OFF_TIMER      8'h18
`define BSWC_OFF_IO_STAT    8'h1c
`define BSWC_OFF_MEM        8'h20
`define BSWC_OFF_CMD        8'h30
`define BSWC_OFF_IO_UPPER   8'h34
`define BSWC_OFF_WIN_STAT   8'h38

// field positions
`define BSWC_TIMER_LSB      24
`define BSWC_IOB_LSB        4
`define BSWC_IOL_LSB        12
`define BSWC_MEMB_LSB       4
`define BSWC_MEML_LSB       20
`define BSWC_CMD_PERR_BIT   6
`define BSWC_ST_MDPE        24
`define BSWC_ST_STA         27
`define BSWC_ST_RTA         28
`define BSWC_ST_RMA         29
`define BSWC_ST_RSE         30
`define BSWC_ST_DPE         31

// fixed read-only values
`define BSWC_IO_32BIT_IND   4'h1
`define BSWC_CLAIM_MEDIUM   2'h1
`define BSWC_CAP_66MHZ      1'b1
`define BSWC_CAP_FBB        1'b0
`define BSWC_MEM_LOW_RO     4'h0

// reset values
`define BSWC_RST_TIMER      8'h00
`define BSWC_RST_NIB        4'h0
`define BSWC_RST_MEM        12'h000
`define BSWC_RST_CMD        16'h0000
`define BSWC_RST_IOUP       32'h00000000

// axi responses
`define BSWC_RESP_OKAY      2'h0
`define BSWC_RESP_SLVERR    2'h2

`endif

//--- logic/bswc_regs.v
// Implementation choice: the AXI4-Lite interface to the registers.
`include "bswc_defs.vh"
`default_nettype none

module bswc_regs (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        downstream_parity_fault_pin_n,
  input  wire        downstream_system_fault_pin_n,
  input  wire        sec_target_abort_sent,
  input  wire        sec_target_abort_rcvd,
  input  wire        sec_master_abort_rcvd,
  input  wire        sec_parity_err_det,
  input  wire [31:0] io_check_addr,
  input  wire [31:0] mem_check_addr,
  output reg         io_forward,
  output reg         mem_forward,
  output reg  [7:0]  sec_timeout_count
);

  reg [7:0]  timer_reg;
  reg [3:0]  iob_reg;
  reg [3:0]  iol_reg;
  reg [11:0] memb_reg;
  reg [11:0] meml_reg;
  reg [15:0] cmd_reg;
  reg [31:0] ioup_reg;
  reg [5:0]  err_reg;
  reg [7:0]  awaddr_reg;
  reg        aw_held;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  reg        w_held;
  reg [5:0]  err_next;
  reg [5:0]  err_set;
  reg [5:0]  err_clr;
  reg [31:0] rd_word;
  reg        rd_hit;
  reg        wr_hit;

  wire [31:0] io_base;
  wire [31:0] io_limit;
  wire [31:0] mem_base;
  wire [31:0] mem_limit;
  wire        do_write;
  wire [31:0] cmd_merged;

  // byte-lane merge, used by the command and I/O upper registers
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i])
          merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  // inclusive range check shared by both windows
  function in_window;
    input [31:0] a;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_window = (a >= lo) && (a <= hi);
    end
  endfunction

  assign io_base   = {ioup_reg[15:0], iob_reg, 12'h000};
  assign io_limit  = {ioup_reg[31:16], iol_reg, 12'hfff};
  assign mem_base  = {memb_reg, 20'h00000};
  assign mem_limit = {meml_reg, 20'hfffff};
  assign do_write  = aw_held && w_held && !s_axi_bvalid;
  // command is 16 bits wide; upper lanes of the merge are dropped on purpose
  assign cmd_merged = merge({16'h0000, cmd_reg}, wdata_reg, wstrb_reg);

  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `BSWC_OFF_TIMER:
        rd_word = {timer_reg, 24'h000000};
      `BSWC_OFF_IO_STAT:
        rd_word = {err_reg[5:1], `BSWC_CLAIM_MEDIUM, err_reg[0],
                   `BSWC_CAP_FBB, 1'b0, `BSWC_CAP_66MHZ,
                   5'h00,
                   iol_reg, `BSWC_IO_32BIT_IND,
                   iob_reg, `BSWC_IO_32BIT_IND};
      `BSWC_OFF_MEM:
        rd_word = {meml_reg, 4'h0, memb_reg, `BSWC_MEM_LOW_RO};
      `BSWC_OFF_CMD:
        rd_word = {16'h0000, cmd_reg};
      `BSWC_OFF_IO_UPPER:
        rd_word = ioup_reg;
      `BSWC_OFF_WIN_STAT:
        rd_word = {30'h00000000, mem_forward, io_forward};
      default: begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b0;
      end
    endcase
  end

  always @* begin
    case (awaddr_reg)
      `BSWC_OFF_TIMER,
      `BSWC_OFF_IO_STAT,
      `BSWC_OFF_MEM,
      `BSWC_OFF_CMD,
      `BSWC_OFF_IO_UPPER,
      `BSWC_OFF_WIN_STAT: wr_hit = 1'b1;
      default:            wr_hit = 1'b0;
    endcase
  end

  // a new event wins over a clear landing in the same cycle
  always @* begin
    err_set = {sec_parity_err_det,
               !downstream_system_fault_pin_n,
               sec_master_abort_rcvd,
               sec_target_abort_rcvd,
               sec_target_abort_sent,
               !downstream_parity_fault_pin_n &&
                 cmd_reg[`BSWC_CMD_PERR_BIT]};
    err_clr = 6'h00;
    if (do_write && awaddr_reg == `BSWC_OFF_IO_STAT &&
        wstrb_reg[3]) begin
      err_clr = {wdata_reg[31:27], wdata_reg[24]};
    end
    err_next = (err_reg & ~err_clr) | err_set;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready     <= 1'b0;
      s_axi_wready      <= 1'b0;
      s_axi_bvalid      <= 1'b0;
      s_axi_bresp       <= `BSWC_RESP_OKAY;
      s_axi_arready     <= 1'b0;
      s_axi_rvalid      <= 1'b0;
      s_axi_rresp       <= `BSWC_RESP_OKAY;
      s_axi_rdata       <= 32'h00000000;
      awaddr_reg        <= 8'h00;
      aw_held           <= 1'b0;
      wdata_reg         <= 32'h00000000;
      wstrb_reg         <= 4'h0;
      w_held            <= 1'b0;
      timer_reg         <= `BSWC_RST_TIMER;
      iob_reg           <= `BSWC_RST_NIB;
      iol_reg           <= `BSWC_RST_NIB;
      memb_reg          <= `BSWC_RST_MEM;
      meml_reg          <= `BSWC_RST_MEM;
      cmd_reg           <= `BSWC_RST_CMD;
      ioup_reg          <= `BSWC_RST_IOUP;
      err_reg           <= 6'h00;
      io_forward        <= 1'b0;
      mem_forward       <= 1'b0;
      sec_timeout_count <= `BSWC_RST_TIMER;
    end else if (ce) begin
      err_reg           <= err_next;
      sec_timeout_count <= timer_reg;
      io_forward  <= in_window(io_check_addr, io_base, io_limit);
      mem_forward <= in_window(mem_check_addr, mem_base, mem_limit);

      // ready pulses for one cycle as each channel is captured
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_held && !s_axi_awready) begin
        awaddr_reg    <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && !w_held && !s_axi_wready) begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b1;
      end

      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `BSWC_RESP_OKAY : `BSWC_RESP_SLVERR;
        case (awaddr_reg)
          `BSWC_OFF_TIMER:
            if (wstrb_reg[3])
              timer_reg <= wdata_reg[`BSWC_TIMER_LSB +: 8];
          `BSWC_OFF_IO_STAT: begin
            if (wstrb_reg[0])
              iob_reg <= wdata_reg[`BSWC_IOB_LSB +: 4];
            if (wstrb_reg[1])
              iol_reg <= wdata_reg[`BSWC_IOL_LSB +: 4];
          end
          `BSWC_OFF_MEM: begin
            if (wstrb_reg[0])
              memb_reg[3:0] <= wdata_reg[7:4];
            if (wstrb_reg[1])
              memb_reg[11:4] <= wdata_reg[15:8];
            if (wstrb_reg[2])
              meml_reg[3:0] <= wdata_reg[23:20];
            if (wstrb_reg[3])
              meml_reg[11:4] <= wdata_reg[31:24];
          end
          `BSWC_OFF_CMD:
            cmd_reg <= cmd_merged[15:0];
          `BSWC_OFF_IO_UPPER:
            ioup_reg <= merge(ioup_reg, wdata_reg, wstrb_reg);
          default: ;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end

      // one read at a time; address taken only while no data waits
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready)
          s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? `BSWC_RESP_OKAY : `BSWC_RESP_SLVERR;
      end
    end
  end

endmodule

`default_nettype wire

//--- sim/bswc_regs_properties.sv
`default_nettype none
module bswc_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_rvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        sec_parity_err_det,
  input wire logic        sec_master_abort_rcvd,
  input wire logic        downstream_system_fault_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rv_q;
  // first beat of an okay read; araddr is still held at that edge
  wire  rd_ok = s_axi_rvalid & ~rv_q & (s_axi_rresp == 2'h0);
  wire  st_rd = rd_ok & (s_axi_araddr == 8'h1c);
  wire  mb_rd = rd_ok & (s_axi_araddr == 8'h20);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) rv_q <= s_axi_rvalid;
  chk_io_ind_nib: assert property (st_rd |->
    s_axi_rdata[3:0] == 4'h1 && s_axi_rdata[11:8] == 4'h1) else $error("io ind");
  chk_cap_bits: assert property (st_rd |->
    s_axi_rdata[21] && !s_axi_rdata[23]) else $error("cap bits");
  chk_rsvd_zero: assert property (st_rd |->
    s_axi_rdata[20:16] == 5'h00 && !s_axi_rdata[22]) else $error("reserved");
  chk_claim_time: assert property (st_rd |->
    s_axi_rdata[26:25] == 2'h1) else $error("claim timing");
  chk_mem_low: assert property (mb_rd |-> s_axi_rdata[3:0] == 4'h0)
    else $error("mem low bits");
  // three cycles of event cover any one-cycle flag latency
  chk_serr_flag: assert property (!downstream_system_fault_pin_n [*3]
    ##1 st_rd |-> s_axi_rdata[30]) else $error("serr flag");
  chk_mabort_flag: assert property (sec_master_abort_rcvd [*3]
    ##1 st_rd |-> s_axi_rdata[29]) else $error("mabort flag");
  chk_perr_flag: assert property (sec_parity_err_det [*3]
    ##1 st_rd |-> s_axi_rdata[31]) else $error("parity flag");
endmodule

bind bswc_regs bswc_chk u_chk (.aclk, .aresetn, .s_axi_rvalid,
  .s_axi_araddr, .s_axi_rdata, .s_axi_rresp, .sec_parity_err_det,
  .sec_master_abort_rcvd, .downstream_system_fault_pin_n);
`default_nettype wire

//--- sim/bswc_sec_agent.sv
`default_nettype none
module bswc_sec_agent (
  input  wire logic       aclk,
  input  wire logic [5:0] ev_req,
  output var  logic       downstream_parity_fault_pin_n,
  output var  logic       downstream_system_fault_pin_n,
  output var  logic [3:0] ev_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins are active low, so an idle agent drives them high
  always @(posedge aclk) begin
    downstream_parity_fault_pin_n <= ~ev_req[0];
    downstream_system_fault_pin_n <= ~ev_req[1];
    ev_out                        <= ev_req[5:2];
  end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        downstream_parity_fault_pin_n, downstream_system_fault_pin_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, io_check_addr, mem_check_addr, v, m;
  logic [3:0]  s_axi_wstrb, ev_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  ev_req;
  logic [7:0]  tcnt;
  logic [65:0] exp_q [$];
  logic [65:0] e;
  logic [33:0] got;
  int          err_count = 0, n_checks = 0, cyc = 0, seed = 88, i;
  logic [31:0] io_tab [4] = '{32'h00011fff, 32'h00012000, 32'h00014fff,
                              32'h00015000};
  logic [31:0] mem_tab [4] = '{32'h11ffffff, 32'h12000000, 32'h123fffff,
                               32'h12400000};
  bswc_regs uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .downstream_parity_fault_pin_n, .downstream_system_fault_pin_n,
    .sec_target_abort_sent(ev_out[0]), .sec_target_abort_rcvd(ev_out[1]),
    .sec_master_abort_rcvd(ev_out[2]), .sec_parity_err_det(ev_out[3]),
    .io_check_addr, .mem_check_addr, .io_forward(), .mem_forward(),
    .sec_timeout_count(tcnt));
  bswc_sec_agent far_end (.aclk, .ev_req, .downstream_parity_fault_pin_n,
    .downstream_system_fault_pin_n, .ev_out);
  always #5 aclk = ~aclk;
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      final_report;
    end
  end
  task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s,
                    input [1:0] r);
    exp_q.push_back({r, 64'h0});
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    fork
      begin
        @(posedge aclk);
        while (!s_axi_awready) @(posedge aclk);
        s_axi_awvalid <= 1'b0;
      end
      begin
        @(posedge aclk);
        while (!s_axi_wready) @(posedge aclk);
        s_axi_wvalid <= 1'b0;
      end
    join
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input [7:0] a, input [31:0] k, input [31:0] x,
                    input [1:0] r);
    exp_q.push_back({r, k, x});
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    @(posedge aclk);
    while (!s_axi_arready) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // compares each response against the oldest note of the driver
  always @(posedge aclk) begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      e = exp_q.pop_front();
      got = s_axi_rready ? {s_axi_rresp, s_axi_rdata & e[63:32]}
                         : {s_axi_bresp, 32'h0};
      n_checks++;
      if (got !== {e[65:64], e[31:0]}) begin
        $display("[ERR] resp_data exp %h got %h", {e[65:64], e[31:0]}, got);
        err_count++;
      end
    end
  end
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
     s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb,
     io_check_addr, mem_check_addr, ev_req} = '0;
    ce = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h18, 32'hffffffff, 32'h0, 2'h0);
    rd(8'h1c, 32'hffffffff, 32'h02200101, 2'h0);
    rd(8'h20, 32'hffffffff, 32'h0, 2'h0);
    v = $random(seed);
    wr(8'h18, v, 4'hf, 2'h0);
    rd(8'h18, 32'hffffffff, {v[31:24], 24'h0}, 2'h0);
    n_checks++;
    if (tcnt !== v[31:24]) begin
      $display("[ERR] timeout_count exp %h got %h", v[31:24], tcnt);
      err_count++;
    end
    wr(8'h1c, 32'h00ffffff, 4'hf, 2'h0);
    rd(8'h1c, 32'hffffffff, 32'h0220f1f1, 2'h0);
    wr(8'h20, 32'hffffffff, 4'hf, 2'h0);
    rd(8'h20, 32'hffffffff, 32'hfff0fff0, 2'h0);
    rd(8'h40, 32'hffffffff, 32'h0, 2'h2);
    wr(8'h44, v, 4'hf, 2'h2);
    wr(8'h1c, 32'h00004020, 4'h3, 2'h0);
    wr(8'h34, 32'h00010001, 4'hf, 2'h0);
    wr(8'h20, 32'h12301200, 4'hf, 2'h0);
    // probes just below, at both ends of, and just above each window
    for (i = 0; i < 4; i++) begin
      {io_check_addr, mem_check_addr} <= {io_tab[i], mem_tab[i]};
      repeat (2) @(posedge aclk);
      rd(8'h38, 32'h3, {30'h0, {2{i == 1 || i == 2}}}, 2'h0);
    end
    ev_req <= 6'h01;
    repeat (3) @(posedge aclk);
    ev_req <= 6'h00;
    repeat (2) @(posedge aclk);
    rd(8'h1c, 32'hf9000000, 32'h0, 2'h0);
    wr(8'h30, 32'h00000040, 4'hf, 2'h0);
    ev_req <= 6'h3f;
    repeat (3) @(posedge aclk);
    rd(8'h1c, 32'hf9000000, 32'hf9000000, 2'h0);
    ev_req <= 6'h00;
    repeat (2) @(posedge aclk);
    wr(8'h1c, 32'h0, 4'h8, 2'h0);
    rd(8'h1c, 32'hf9000000, 32'hf9000000, 2'h0);
    m = 32'hf9000000;
    for (i = 24; i < 32; i++) begin
      m[i] = 1'b0;
      wr(8'h1c, 32'h1 << i, 4'h8, 2'h0);
      rd(8'h1c, 32'hf9000000, m, 2'h0);
    end
    // an event in the same cycle as its clear must keep the flag set
    ev_req <= 6'h20;
    repeat (2) @(posedge aclk);
    wr(8'h1c, 32'h80000000, 4'h8, 2'h0);
    rd(8'h1c, 32'h80000000, 32'h80000000, 2'h0);
    ev_req <= 6'h00;
    repeat (2) @(posedge aclk);
    wr(8'h1c, 32'h80000000, 4'h8, 2'h0);
    rd(8'h1c, 32'hf9000000, 32'h0, 2'h0);
    // with the enable low no event may reach the flags
    ce <= 1'b0;
    ev_req <= 6'h3f;
    repeat (3) @(posedge aclk);
    ev_req <= 6'h00;
    repeat (2) @(posedge aclk);
    ce <= 1'b1;
    @(posedge aclk);
    rd(8'h1c, 32'hf9000000, 32'h0, 2'h0);
    final_report;
  end
endmodule
`default_nettype wire
